// >>> logic/throttle_pkg.sv
/*
  package for the activate throttler: register offsets, reset values, window
  lengths and the carrier structs used by the throttler.
  assumes a 32-bit ahb-lite register bus and a 10 mhz core clock.
*/
package throttle_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] limits_off = 8'h04;
  localparam logic [7:0] gbl_off    = 8'h08;
  localparam logic [7:0] elec_off   = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;
  // control field positions
  localparam int closed_loop_pos   = 0;
  localparam int step_mode_pos     = 1;
  localparam int short_window_pos  = 2;
  // limit values that mean unrestricted, and the staircase step
  localparam logic [7:0] limit_off_zero = 8'h00;
  localparam logic [7:0] limit_full     = 8'ha8;
  localparam logic [7:0] stair_step     = 8'h02;
  // reset values
  localparam logic [31:0] ctrl_rst   = 32'h0000_0000;
  localparam logic [31:0] limits_rst = 32'h0000_0000;
  localparam logic [7:0]  gbl_rst    = 8'h00;
  localparam logic [31:0] elec_rst   = 32'h0000_3400;
  // global window, counted in core clocks
  localparam int thermal_window    = 1344;
  localparam int gbl_mult_normal   = 16384;
  localparam int gbl_mult_short    = 4;
  localparam int gbl_hold_normal   = 16;
  localparam int gbl_hold_short    = 2;
  localparam int acts_per_unit     = 65536;
  // configuration ring latency and spacing, in core clocks
  localparam int ring_latency      = 40;
  localparam int write_spacing     = 80;
  // electrical window lengths by speed selection
  localparam int elec_hist_len     = 20;
  localparam logic [4:0] ewin_slow_1to1 = 5'd10;
  localparam logic [4:0] ewin_slow_5to4 = 5'd13;
  localparam logic [4:0] ewin_mid       = 5'd13;
  localparam logic [4:0] ewin_safe      = 5'd20;
  localparam logic [2:0] elec_limit_rst = 3'd4;

  typedef enum logic [1:0] {
    spd_slow_1to1 = 2'b00,
    spd_slow_5to4 = 2'b01,
    spd_mid       = 2'b10,
    spd_safe      = 2'b11
  } speed_sel_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } limits_t;

  typedef struct packed {
    logic        closed_loop_select;
    logic        step_mode_select;
    logic        short_window_mode;
  } ctrl_t;
endpackage

// >>> logic/pending_write_mem.sv
/*
  holds register writes while they travel the configuration ring; a small
  delay line of words whose output comes from a register.
  assumes the writer keeps one write in flight at a time.
*/
`timescale 1ns/100ps
module pending_write_mem #(
  parameter int width = 36,
  parameter int depth = 40
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // write side
  input  wire logic             wr_valid,
  input  wire logic [width-1:0] wr_data,
  // read side
  output logic                  rd_valid_q,
  output logic [width-1:0]      rd_data_q
);
  logic [depth-1:0] valid_pipe_q;
  logic [width-1:0] data_pipe_q [depth];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_pipe_q <= '0;
      rd_valid_q   <= 1'b0;
      rd_data_q    <= '0;
    end else if (ce) begin
      valid_pipe_q <= {valid_pipe_q[depth-2:0], wr_valid};
      rd_valid_q   <= valid_pipe_q[depth-2];
      rd_data_q    <= data_pipe_q[depth-2];
    end
  end

  always_ff @(posedge hclk) begin
    if (ce) begin
      data_pipe_q[0] <= wr_data;
      for (int i = 1; i < depth; i++) begin
        data_pipe_q[i] <= data_pipe_q[i-1];
      end
    end
  end
endmodule

// >>> logic/activate_throttler.sv
/*
  activate throttler: open-loop global window throttling, closed-loop
  staircase / single-step throttling and per-rank electrical throttling,
  with its registers on an ahb-lite slave.
  assumes one activate scheduler per instance, a 10 mhz core clock and
  writes spaced by the configuration software.
*/
// Behaviour
// - hunt field picks open or closed loop
// - register writes take effect 40 clocks later
// - global excess sets flag for 16 windows
// - new low/mid limits apply immediately
// - mid crossing picks staircase or single step
// - staircase value is max(old minus 2, high)
// - high above active value resets active value
// - hunt cleared ignores temperature entirely
// - limits 0 or 168 mean unrestricted
// - global unit allows 65536 activates per window
// - electrical enable per dimm pair, ranks share
// - at most 4 activates per rank window
// - electrical window length follows dimm speed
// - configuration field sets electrical activate limit
// - 20-bit per-rank activate history register
// - block rank activates while sum reaches limit
// - history bits beyond window forced to zero
// - flag holds until 16 or 2 clean windows
// - global window 16384 or 4 times 1344
// - flag set uses mid limit instead of low
// - windows counted in core clocks
`timescale 1ns/100ps
module activate_throttler #(
  parameter int pairs         = 2,
  parameter int gbl_window    = throttle_pkg::gbl_mult_normal * throttle_pkg::thermal_window,
  parameter int short_window  = throttle_pkg::gbl_mult_short * throttle_pkg::thermal_window,
  parameter int unit_acts     = throttle_pkg::acts_per_unit
) (
  // clock, reset, enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // activate scheduler: one request bit per rank (two ranks per pair)
  input  wire logic [2*pairs-1:0]   act_issued,
  output logic [2*pairs-1:0]        rank_block,
  // temperature feedback
  input  wire logic                 temp_above_mid,
  input  wire logic                 throttle_tick,
  // throttle state
  output logic [7:0]                active_throttle_value,
  output logic                      global_throttle_flag
);
  localparam int ranks = 2 * pairs;

  // register state
  throttle_pkg::ctrl_t   ctrl_q;
  throttle_pkg::limits_t lim_q;
  logic [7:0]            global_activate_limit;
  logic [pairs-1:0]      electrical_throttle_enable;
  logic [2:0]            electrical_activate_limit;
  throttle_pkg::speed_sel_t speed_q;

  // ahb address phase; only whole-word transfers are taken
  logic       wr_pend_q;
  logic [7:0] addr_q;
  wire        word_acc = hsize == 3'b010;
  wire        take     = hsel && hready && htrans[1] && word_acc;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (ce) begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // writes travel the ring before landing
  logic        ring_valid;
  logic [39:0] ring_data;
  pending_write_mem #(
    .width (40),
    .depth (throttle_pkg::ring_latency)
  ) u_ring (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .wr_valid   (wr_pend_q),
    .wr_data    ({addr_q, hwdata}),
    .rd_valid_q (ring_valid),
    .rd_data_q  (ring_data)
  );
  wire [7:0]  ring_addr = ring_data[39:32];
  wire [31:0] ring_word = ring_data[31:0];
  wire        ld_ctrl   = ring_valid && ring_addr == throttle_pkg::ctrl_off;
  wire        ld_lim    = ring_valid && ring_addr == throttle_pkg::limits_off;
  wire        ld_gbl    = ring_valid && ring_addr == throttle_pkg::gbl_off;
  wire        ld_elec   = ring_valid && ring_addr == throttle_pkg::elec_off;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q                     <= throttle_pkg::ctrl_t'(throttle_pkg::ctrl_rst[2:0]);
      lim_q                      <= throttle_pkg::limits_t'(throttle_pkg::limits_rst[23:0]);
      global_activate_limit      <= throttle_pkg::gbl_rst;
      electrical_throttle_enable <= '0;
      electrical_activate_limit  <= throttle_pkg::elec_limit_rst;
      speed_q                    <= throttle_pkg::spd_safe;
    end else if (ce) begin
      if (ld_ctrl) begin
        ctrl_q <= {ring_word[throttle_pkg::closed_loop_pos],
                   ring_word[throttle_pkg::step_mode_pos],
                   ring_word[throttle_pkg::short_window_pos]};
      end
      if (ld_lim) begin
        lim_q <= ring_word[23:0];
      end
      if (ld_gbl) begin
        global_activate_limit <= ring_word[7:0];
      end
      if (ld_elec) begin
        electrical_throttle_enable <= ring_word[pairs-1:0];
        electrical_activate_limit  <= ring_word[10:8];
        speed_q <= throttle_pkg::speed_sel_t'(ring_word[13:12]);
      end
    end
  end

  function automatic logic unlimited(input logic [7:0] v);
    return v == throttle_pkg::limit_off_zero || v == throttle_pkg::limit_full;
  endfunction

  // global window counter, core clocks
  logic [31:0] win_cnt_q;
  wire  [31:0] win_len  = ctrl_q.short_window_mode ? 32'(short_window) : 32'(gbl_window);
  wire         win_end  = win_cnt_q >= win_len - 32'd1;
  logic [31:0] pair_cnt_q [pairs];
  logic [pairs-1:0] pair_over;
  logic        excess_q;
  wire  [31:0] gbl_cap = 32'(global_activate_limit) * 32'(unit_acts);
  for (genvar p = 0; p < pairs; p++) begin : g_pair
    assign pair_over[p] = !unlimited(global_activate_limit) && pair_cnt_q[p] > gbl_cap;
  end
  wire         win_excess = excess_q || |pair_over;
  logic [4:0]  hold_q;
  wire  [4:0]  hold_len = ctrl_q.short_window_mode ? 5'(throttle_pkg::gbl_hold_short)
                                                   : 5'(throttle_pkg::gbl_hold_normal);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt_q            <= 32'h0000_0000;
      excess_q             <= 1'b0;
      hold_q               <= 5'h00;
      global_throttle_flag <= 1'b0;
      for (int p = 0; p < pairs; p++) pair_cnt_q[p] <= 32'h0000_0000;
    end else if (ce) begin
      win_cnt_q <= win_end ? 32'h0000_0000 : win_cnt_q + 32'd1;
      excess_q  <= win_end ? 1'b0 : win_excess;
      for (int p = 0; p < pairs; p++) begin
        if (win_end) pair_cnt_q[p] <= 32'h0000_0000;
        else pair_cnt_q[p] <= pair_cnt_q[p] + 32'(act_issued[2*p] & ~rank_block[2*p])
                            + 32'(act_issued[2*p+1] & ~rank_block[2*p+1]);
      end
      if (win_end) begin
        if (win_excess) begin
          global_throttle_flag <= 1'b1;
          hold_q               <= hold_len;
        end else if (hold_q > 5'd1) begin
          hold_q <= hold_q - 5'd1;
        end else begin
          hold_q               <= 5'h00;
          global_throttle_flag <= 1'b0;
        end
      end
    end
  end

  // active throttle value
  wire [7:0] open_val  = global_throttle_flag ? lim_q.mid : lim_q.low;
  wire [7:0] stair_sub = active_throttle_value > throttle_pkg::stair_step
                         ? active_throttle_value - throttle_pkg::stair_step : 8'h00;
  wire [7:0] stair_val = stair_sub > lim_q.high ? stair_sub : lim_q.high;
  wire       use_temp  = ctrl_q.closed_loop_select && temp_above_mid;
  logic [7:0] thr_d;
  always_comb begin
    thr_d = active_throttle_value;
    if (!use_temp) begin
      thr_d = open_val;
    end else if (ctrl_q.step_mode_select) begin
      thr_d = lim_q.high;
    end else if (lim_q.high > active_throttle_value) begin
      thr_d = lim_q.high;
    end else if (throttle_tick) begin
      thr_d = stair_val;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) active_throttle_value <= 8'h00;
    else if (ce)  active_throttle_value <= thr_d;
  end

  // electrical sliding window
  logic [4:0] ewin;
  always_comb begin
    unique case (speed_q)
      throttle_pkg::spd_slow_1to1: ewin = throttle_pkg::ewin_slow_1to1;
      throttle_pkg::spd_slow_5to4: ewin = throttle_pkg::ewin_slow_5to4;
      throttle_pkg::spd_mid:       ewin = throttle_pkg::ewin_mid;
      throttle_pkg::spd_safe:      ewin = throttle_pkg::ewin_safe;
    endcase
  end
  logic [throttle_pkg::elec_hist_len-1:0] win_mask;
  always_comb begin
    for (int b = 0; b < throttle_pkg::elec_hist_len; b++) begin
      win_mask[b] = 5'(b) < ewin;
    end
  end
  logic [throttle_pkg::elec_hist_len-1:0] hist_q [ranks];
  logic [4:0] ecount [ranks];
  logic [ranks-1:0] block_d;
  always_comb begin
    for (int r = 0; r < ranks; r++) begin
      ecount[r] = 5'h00;
      for (int b = 0; b < throttle_pkg::elec_hist_len - 1; b++) begin
        ecount[r] = ecount[r] + 5'(hist_q[r][b] & win_mask[b + 1]);
      end
      block_d[r] = electrical_throttle_enable[r/2]
                   && ecount[r] + 5'(act_issued[r] & ~rank_block[r])
                      >= 5'(electrical_activate_limit);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rank_block <= '0;
      for (int r = 0; r < ranks; r++) hist_q[r] <= '0;
    end else if (ce) begin
      rank_block <= block_d;
      for (int r = 0; r < ranks; r++) begin
        hist_q[r] <= {hist_q[r][throttle_pkg::elec_hist_len-2:0],
                      act_issued[r] & ~rank_block[r]} & win_mask;
      end
    end
  end

  // read data are decoded from the address phase and launched at its edge, so that
  // they already stand in the zero-wait data phase
  wire        rd_take = take && !hwrite;
  wire [31:0] rd_mux =
    haddr == throttle_pkg::ctrl_off   ? {29'h0, ctrl_q.short_window_mode,
                                         ctrl_q.step_mode_select, ctrl_q.closed_loop_select} :
    haddr == throttle_pkg::limits_off ? {8'h00, lim_q} :
    haddr == throttle_pkg::gbl_off    ? {24'h0, global_activate_limit} :
    haddr == throttle_pkg::elec_off   ? 32'({speed_q, 1'b0, electrical_activate_limit,
                                             8'(electrical_throttle_enable)}) :
    haddr == throttle_pkg::status_off ? {23'h0, global_throttle_flag, active_throttle_value} :
    32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rd_take ? rd_mux : hrdata;
    end
  end

  // a taken write shows at the ring output one latency plus the sampling edge later;
  // a frozen clock enable breaks the count, so such attempts are dropped
  sequence write_taken_s;
    take && hwrite;
  endsequence
  sequence ring_arrival_s;
    ##41 ring_valid;
  endsequence

  staircase_floor_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && use_temp ##1 ce |-> active_throttle_value >= lim_q.high || $past(ld_lim))
    else $error("active value fell below high limit");
  flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && win_end && win_excess |=> global_throttle_flag)
    else $error("global flag not set after excess");
  flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && global_throttle_flag && !(win_end && !win_excess && hold_q <= 5'd1)
    |=> global_throttle_flag)
    else $error("global flag dropped before its hold ran out");
  elec_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && block_d[0] |=> rank_block[0])
    else $error("rank not blocked at limit");
  ring_delay_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    write_taken_s |-> ring_arrival_s)
    else $error("register write did not arrive after the ring delay");
  single_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && use_temp && ctrl_q.step_mode_select
    |=> active_throttle_value == $past(lim_q.high))
    else $error("single step did not apply the high limit");
  open_loop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !ctrl_q.closed_loop_select
    |=> active_throttle_value == $past(global_throttle_flag ? lim_q.mid : lim_q.low))
    else $error("open loop value is not the low or mid limit");
endmodule

// >>> verification/act_scheduler_model.sv
/*
  activate scheduler model: offers activates per rank and issues only
  those that the throttler leaves unblocked.
  assumes rank_block is a level that holds for the whole cycle.
*/
`timescale 1ns/100ps
module act_scheduler_model #(
  parameter int ranks = 4
) (
  // requests from the bench
  input  wire logic [ranks-1:0] want,
  // throttler side
  input  wire logic [ranks-1:0] rank_block,
  output logic      [ranks-1:0] act_issued
);
  // a blocked rank waits; the request is offered again next cycle
  assign act_issued = want & ~rank_block;
endmodule

// >>> verification/activate_throttler_tb_top.sv
/*
  bench for the activate throttler: ahb-lite register tasks, the scheduler
  model and directed sequences with expected values.
  assumes the short sim windows set below and zero-wait bus answers.
*/
`timescale 1ns/100ps
module activate_throttler_tb_top;
  localparam int gwin = 100;
  localparam int swin = 20;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        temp_above_mid, throttle_tick, flag;
  logic [7:0]  haddr, atv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic [3:0]  want, act, blk;
  logic [19:0] hist;
  int          err_total, n_compared, ewin, elim, i, n0, o0, b1, b2, f0, c0;
  int          nact = 0, over = 0, nb1 = 0, nb2 = 0, nfl = 0, cyc = 0;
  int          ewl[4] = '{int'(throttle_pkg::ewin_slow_1to1), int'(throttle_pkg::ewin_slow_5to4),
                          int'(throttle_pkg::ewin_mid), int'(throttle_pkg::ewin_safe)};

  activate_throttler #(
    .pairs        (2),
    .gbl_window   (gwin),
    .short_window (swin),
    .unit_acts    (4)
  ) i_dut (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ce                    (1'b1),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hreadyout),
    .hrdata                (hrdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .act_issued            (act),
    .rank_block            (blk),
    .temp_above_mid        (temp_above_mid),
    .throttle_tick         (throttle_tick),
    .active_throttle_value (atv),
    .global_throttle_flag  (flag)
  );

  act_scheduler_model #(.ranks(4)) i_sched (
    .want       (want),
    .rank_block (blk),
    .act_issued (act)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // counters only grow, so sequences compare deltas and never race a clear
  always @(posedge hclk) begin
    hist <= {hist[18:0], act[0]};
    nact <= nact + int'(act[0]);
    nb1 <= nb1 + int'(blk[1] === 1'b1);
    nb2 <= nb2 + int'(blk[2] === 1'b1);
    nfl <= nfl + int'(flag === 1'b1);
    cyc <= cyc + 1;
    if (ewin > 0 && $countones({hist[18:0], act[0]} & ((20'h1 << ewin) - 20'h1)) > elim)
      over <= over + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  // spacing covers the ring delay too, so the value is in force on return
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    repeat (85) @(posedge hclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(a, 1'b0, 32'h0);
    chk(what, exp, rv);
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_flag(input logic v, input int lim);
    for (int n = 0; n < lim && flag !== v; n++)
      @(posedge hclk);
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // generous against the few thousand cycles the sequences need
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    results();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    temp_above_mid = 1'b0;
    throttle_tick = 1'b0;
    want = 4'h0;
    err_total = 0;
    n_compared = 0;
    ewin = 0;
    elim = 4;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(throttle_pkg::ctrl_off, throttle_pkg::ctrl_rst, "ctrl");
    rdc(throttle_pkg::limits_off, throttle_pkg::limits_rst, "limits");
    rdc(throttle_pkg::gbl_off, {24'h0, throttle_pkg::gbl_rst}, "global limit");
    rdc(throttle_pkg::elec_off, throttle_pkg::elec_rst, "electrical");
    rdc(throttle_pkg::status_off, 32'h0, "status");
    wr(8'h14, 32'hffff_ffff);
    rdc(8'h14, 32'h0, "unmapped");
    xfer(throttle_pkg::limits_off, 1'b1, 32'h0018_3020);
    repeat (30) @(posedge hclk);
    chk("early value", 32'h0, {24'h0, atv});
    repeat (55) @(posedge hclk);
    chk("low in use", 32'h20, {24'h0, atv});
    b1 = nb1;
    b2 = nb2;
    for (i = 0; i < 4; i++) begin
      elim = (i == 1) ? 2 : 4;
      want <= 4'h0;
      wr(throttle_pkg::elec_off, {18'h0, 2'(i), 1'b0, 3'(elim), 6'h0, 2'b01});
      ewin = ewl[i];
      want <= 4'hf;
      n0 = nact;
      o0 = over;
      repeat (4 * ewin) @(posedge hclk);
      chk("window overrun", 32'(o0), 32'(over));
      chk("window length", 32'h1, 32'((nact - n0) >= 3 * elim));
      ewin = 0;
    end
    chk("shared enable", 32'h1, 32'(nb1 > b1));
    chk("other pair free", 32'(b2), 32'(nb2));
    want <= 4'h0;
    wr(throttle_pkg::elec_off, throttle_pkg::elec_rst);
    want <= 4'hf;
    repeat (3 * gwin) @(posedge hclk);
    chk("flag at limit 0", 32'h0, {31'h0, flag});
    want <= 4'h0;
    wr(throttle_pkg::gbl_off, 32'h1);
    want <= 4'hf;
    wait_flag(1'b1, 3 * gwin);
    want <= 4'h0;
    chk("flag set", 32'h1, {31'h0, flag});
    repeat (2) @(posedge hclk);
    chk("mid in use", 32'h30, {24'h0, atv});
    f0 = nfl;
    c0 = cyc;
    wr(throttle_pkg::limits_off, 32'h0018_3422);
    chk("new mid", 32'h34, {24'h0, atv});
    repeat (1400) @(posedge hclk);
    chk("flag hold", 32'(cyc - c0), 32'(nfl - f0));
    wait_flag(1'b0, 500);
    chk("flag clear", 32'h0, {31'h0, flag});
    repeat (2) @(posedge hclk);
    chk("new low", 32'h22, {24'h0, atv});
    wr(throttle_pkg::ctrl_off, 32'h4);
    rdc(throttle_pkg::ctrl_off, 32'h4, "ctrl short window");
    want <= 4'hf;
    wait_flag(1'b1, 3 * swin);
    want <= 4'h0;
    f0 = nfl;
    c0 = cyc;
    repeat (30) @(posedge hclk);
    chk("short hold", 32'(cyc - c0), 32'(nfl - f0));
    wait_flag(1'b0, 40);
    chk("short clear", 32'h0, {31'h0, flag});
    wr(throttle_pkg::gbl_off, 32'h0);
    wr(throttle_pkg::ctrl_off, 32'h1);
    chk("below mid", 32'h22, {24'h0, atv});
    temp_above_mid <= 1'b1;
    repeat (3) @(posedge hclk);
    for (i = 1; i <= 7; i++) begin
      throttle_tick <= 1'b1;
      @(posedge hclk);
      throttle_tick <= 1'b0;
      repeat (3) @(posedge hclk);
      if (i == 7)
        chk("stair floor", 32'h1c, {24'h0, atv});
      else
        chk("stair", 32'((34 - 2 * i > 24) ? 34 - 2 * i : 24), {24'h0, atv});
      if (i == 6)
        wr(throttle_pkg::limits_off, 32'h001c_3422);
      if (i == 6)
        chk("high reset", 32'h1c, {24'h0, atv});
    end
    wr(throttle_pkg::ctrl_off, 32'h3);
    chk("single step", 32'h1c, {24'h0, atv});
    wr(throttle_pkg::ctrl_off, 32'h0);
    chk("temp ignored", 32'h22, {24'h0, atv});
    rdc(throttle_pkg::status_off, 32'h0000_0022, "status");
    results();
  end
endmodule
